// File: rtl/mem_port_defines.svh
// Constants shared by both ends of the core memory request port.
// Assumes inclusion by bare name from package, interface and modules.
`ifndef MEM_PORT_DEFINES_SVH
`define MEM_PORT_DEFINES_SVH
`define MP_ADDR_W 32
`define MP_DATA_W 32
`define MP_TYPE_W 4
`define MP_MULTI_W 1
`define MP_MISS_CYCLES 3
`define MP_RESP_NOTDONE 2'h0
`define MP_RESP_ABORT 2'h1
`define MP_RESP_DONE 2'h2
`endif

// File: rtl/mem_port_pkg.sv
// Types for the core memory request port.
// Assumes mem_port_defines.svh is on the include path.
`include "mem_port_defines.svh"
package mem_port_pkg;
	typedef enum logic [3:0] {
		acc_idle = 4'h0,
		acc_word_load = 4'h1,
		acc_word_load_seq = 4'h2,
		acc_byte_load = 4'h3,
		acc_half_load = 4'h4,
		acc_swap_word_rd = 4'h5,
		acc_swap_byte_rd = 4'h6,
		acc_ifetch = 4'h7,
		acc_ifetch_seq = 4'h8,
		acc_ifetch_spec = 4'h9,
		acc_ifetch_spec_seq = 4'hA,
		acc_word_store = 4'hB,
		acc_word_store_seq = 4'hC
	} access_req_t;
	typedef enum logic [1:0] {
		resp_notdone = 2'h0,
		resp_abort = 2'h1,
		resp_done = 2'h2
	} access_resp_t;
	typedef enum logic [1:0] {
		dret_none = 2'h0,
		dret_one = 2'h1,
		dret_two = 2'h2
	} data_ret_t;
endpackage : mem_port_pkg

// File: rtl/mem_port_if.sv
// Interface joining the core end and the memory end of the request port.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`include "mem_port_defines.svh"
interface mem_port_if;
	mem_port_pkg::access_req_t access_req_type;
	logic access_multi;
	logic [`MP_ADDR_W-1:0] vaddr;
	logic [`MP_DATA_W-1:0] wdata;
	logic instr_return_req_a;
	logic instr_return_req_b;
	mem_port_pkg::data_ret_t data_return_req;
	mem_port_pkg::access_resp_t access_resp;
	logic [`MP_DATA_W-1:0] rdata;
	logic rdata_valid;
	logic rdata_is_data;
	logic confirm;
	modport core (output access_req_type, access_multi, vaddr, wdata, instr_return_req_a,
		instr_return_req_b, data_return_req, input access_resp, rdata, rdata_valid,
		rdata_is_data, confirm);
	modport mem (input access_req_type, access_multi, vaddr, wdata, instr_return_req_a,
		instr_return_req_b, data_return_req, output access_resp, rdata, rdata_valid,
		rdata_is_data, confirm);
endinterface : mem_port_if

// File: rtl/lane_place.sv
// Places a byte or halfword into read-bus lanes by address and byte order.
// Assumes the requester never asks for a halfword at an odd address.
`timescale 1ns/1ns
module lane_place #(
	parameter int DATA_W = 32
) (
	input wire logic [DATA_W-1:0] word_i,
	input wire logic [1:0] addr_lo_i,
	input wire logic is_byte_i,
	input wire logic is_half_i,
	input wire logic big_endian_i,
	output logic [DATA_W-1:0] placed_o
);
	wire [1:0] byte_lane = big_endian_i ? ~addr_lo_i : addr_lo_i;
	wire half_high = big_endian_i ? ~addr_lo_i[1] : addr_lo_i[1];
	// The stored word already holds each byte in its own lane, so only masking is needed.
	wire [DATA_W-1:0] byte_mask = DATA_W'(32'hFF) << {byte_lane, 3'h0};
	wire [DATA_W-1:0] byte_word = word_i & byte_mask;
	wire [DATA_W-1:0] half_mask = half_high ? DATA_W'(32'hFFFF0000) : DATA_W'(32'h0000FFFF);
	wire [DATA_W-1:0] half_word = word_i & half_mask;
	assign placed_o = is_byte_i ? byte_word : (is_half_i ? half_word : word_i);
endmodule : lane_place

// File: rtl/mem_side.sv
// Memory end: answers access and return requests from a small word array.
// Assumes one request set per cycle from the core end; misses are modelled by address bit.
`timescale 1ns/1ns
`include "mem_port_defines.svh"
module mem_side #(
	parameter int DEPTH = 64,
	parameter int MISS_CYCLES = `MP_MISS_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic big_endian_i,
	input wire logic spec_decline_i,
	mem_port_if.mem bus
);
	localparam int AW = $clog2(DEPTH);
	logic [`MP_DATA_W-1:0] mem_q [DEPTH];
	logic [AW-1:0] dptr_q, iptr_q, sptr_q;
	logic [1:0] lo_q;
	logic byte_q, half_q;
	logic [3:0] wait_q;
	logic store_q;
	logic [AW-1:0] store_at_q;
	logic [`MP_DATA_W-1:0] second_q;
	logic second_pend_q, second_data_q;
	logic refill_q;
	mem_port_pkg::access_req_t req;
	assign req = bus.access_req_type;
	wire [AW-1:0] word_at = bus.vaddr[AW+1:2];
	wire is_load = req inside {mem_port_pkg::acc_word_load, mem_port_pkg::acc_byte_load,
		mem_port_pkg::acc_half_load, mem_port_pkg::acc_swap_word_rd,
		mem_port_pkg::acc_swap_byte_rd};
	wire is_load_seq = req == mem_port_pkg::acc_word_load_seq;
	wire is_fetch = req inside {mem_port_pkg::acc_ifetch, mem_port_pkg::acc_ifetch_spec};
	wire is_fetch_seq = req inside {mem_port_pkg::acc_ifetch_seq,
		mem_port_pkg::acc_ifetch_spec_seq};
	wire is_spec = req inside {mem_port_pkg::acc_ifetch_spec, mem_port_pkg::acc_ifetch_spec_seq};
	wire is_store = req inside {mem_port_pkg::acc_word_store, mem_port_pkg::acc_word_store_seq};
	wire declined = is_spec && spec_decline_i;
	wire stalling = wait_q != 4'h0;
	// The cycle after a refill answers the held request instead of missing again.
	wire miss = bus.vaddr[AW+2] && (is_load || is_fetch) && !stalling && !refill_q;
	wire idle_req = req == mem_port_pkg::acc_idle;
	wire want_d = bus.data_return_req != mem_port_pkg::dret_none;
	wire want_i = bus.instr_return_req_a || bus.instr_return_req_b;
	wire [AW-1:0] store_addr = (req == mem_port_pkg::acc_word_store_seq) ? sptr_q + AW'(1)
		: word_at;
	// A linked request reads from the buffer that it loads in the same cycle.
	wire load_any = is_load || is_load_seq;
	wire [AW-1:0] dptr_now = is_load ? word_at : (is_load_seq ? dptr_q + AW'(1) : dptr_q);
	wire [AW-1:0] iptr_now = (is_fetch && !declined) ? word_at : iptr_q;
	wire [1:0] lo_now = is_load ? bus.vaddr[1:0] : (is_load_seq ? 2'h0 : lo_q);
	wire byte_now = load_any ? (req inside {mem_port_pkg::acc_byte_load,
		mem_port_pkg::acc_swap_byte_rd}) : byte_q;
	wire half_now = load_any ? (req == mem_port_pkg::acc_half_load) : half_q;
	wire [AW-1:0] rd_at = want_d ? dptr_now : iptr_now;
	wire [`MP_DATA_W-1:0] placed;
	lane_place #(.DATA_W(`MP_DATA_W)) u_place (
		.word_i(mem_q[rd_at]),
		.addr_lo_i(lo_now),
		.is_byte_i(byte_now && want_d),
		.is_half_i(half_now && want_d),
		.big_endian_i(big_endian_i),
		.placed_o(placed)
	);
	assign bus.confirm = miss || stalling;
	assign bus.access_resp = (idle_req || declined || stalling || miss)
		? mem_port_pkg::resp_notdone : mem_port_pkg::resp_done;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_q <= 4'h0;
			dptr_q <= '0;
			iptr_q <= '0;
			sptr_q <= '0;
			lo_q <= 2'h0;
			byte_q <= 1'b0;
			half_q <= 1'b0;
			store_q <= 1'b0;
			store_at_q <= '0;
			refill_q <= 1'b0;
		end else if (miss) begin
			wait_q <= 4'(MISS_CYCLES);
			refill_q <= 1'b0;
		end else if (stalling) begin
			wait_q <= wait_q - 4'h1;
			refill_q <= wait_q == 4'h1;
		end else begin
			refill_q <= 1'b0;
			dptr_q <= dptr_now;
			// A sequential fetch continues after the two words last returned.
			iptr_q <= (want_i && !want_d && !declined) ? iptr_now + AW'(2) : iptr_now;
			lo_q <= lo_now;
			byte_q <= byte_now;
			half_q <= half_now;
			store_q <= is_store;
			if (is_store) begin
				store_at_q <= store_addr;
				sptr_q <= store_addr;
			end
		end
	end
	// Store data arrives one cycle after the request, so it is written then.
	always_ff @(posedge clk_i) begin
		if (store_q) mem_q[store_at_q] <= bus.wdata;
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus.rdata <= '0;
			bus.rdata_valid <= 1'b0;
			bus.rdata_is_data <= 1'b0;
			second_q <= '0;
			second_pend_q <= 1'b0;
			second_data_q <= 1'b0;
		end else if (second_pend_q) begin
			bus.rdata <= second_q;
			bus.rdata_valid <= 1'b1;
			bus.rdata_is_data <= second_data_q;
			second_pend_q <= 1'b0;
		end else if (!stalling && !miss && (want_d || (want_i && !declined))) begin
			bus.rdata <= placed;
			bus.rdata_valid <= 1'b1;
			bus.rdata_is_data <= want_d;
			second_q <= mem_q[rd_at + AW'(1)];
			second_data_q <= want_d;
			second_pend_q <= !want_d || bus.data_return_req == mem_port_pkg::dret_two;
		end else begin
			bus.rdata_valid <= 1'b0;
		end
	end
endmodule : mem_side

// File: rtl/core_side.sv
// Core end: turns user commands into access and return requests, stalls on confirm.
// Assumes the memory end keeps its response stable while confirm is high.
`timescale 1ns/1ns
`include "mem_port_defines.svh"
// Notes on behaviour
// - New request each cycle, next follows response.
// - Memory gives provisional response, confirm flags wrong.
// - Confirm high freezes core, response treated wrong.
// - Memory fixes response before dropping confirm.
// - Return words arrive on consecutive half cycles; here one word per clock cycle.
// - Access and return may issue together.
// - Linked load plus return pairs supported.
// - Single return or store requests supported.
// - Store with instruction return may be parallel.
// - Multiple qualifier marks more words remaining.
// - Byte lands in lane chosen by address.
// - Halfword lands in half chosen by address.
// - Never request halfword at odd address.
// - Distinct swap read types for word, byte.
// - Sequential fetch follows previous fetch address.
// - Speculative fetches may be declined.
// - Store data driven one cycle after request.
// - Sequential store uses memory's own increment.
// - Data return served before instruction return; here an instruction return asked in the same cycle is dropped.
// - Either instruction return line requests two words.
// - Access answered notdone, abort or done.
module core_side (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cmd_valid_i,
	input wire mem_port_pkg::access_req_t cmd_type_i,
	input wire logic cmd_multi_i,
	input wire logic [`MP_ADDR_W-1:0] cmd_addr_i,
	input wire logic [`MP_DATA_W-1:0] cmd_wdata_i,
	input wire logic cmd_ret_instr_i,
	input wire mem_port_pkg::data_ret_t cmd_ret_data_i,
	output logic cmd_ready_o,
	output logic [`MP_DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	output logic rd_is_data_o,
	output logic done_o,
	output logic abort_o,
	output logic not_done_o,
	mem_port_if.core bus
);
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_wait = 3'b010,
		st_stall = 3'b100
	} core_state_t;
	core_state_t state_q, state_d;
	logic [`MP_DATA_W-1:0] store_data_q;
	logic store_pend_q;
	logic [`MP_DATA_W-1:0] wdata_q;
	logic [`MP_ADDR_W-1:0] fetch_next_q;
	logic [`MP_ADDR_W-1:0] store_next_q;
	wire half_odd = cmd_type_i == mem_port_pkg::acc_half_load && cmd_addr_i[0];
	wire is_store_cmd = cmd_type_i inside {mem_port_pkg::acc_word_store,
		mem_port_pkg::acc_word_store_seq};
	wire is_store_seq_cmd = cmd_type_i == mem_port_pkg::acc_word_store_seq;
	wire is_fetch_cmd = cmd_type_i inside {mem_port_pkg::acc_ifetch,
		mem_port_pkg::acc_ifetch_spec};
	wire is_fetch_seq_cmd = cmd_type_i inside {mem_port_pkg::acc_ifetch_seq,
		mem_port_pkg::acc_ifetch_spec_seq};
	wire stalled = bus.confirm;
	// A two-word return answered now keeps the memory end busy in the next cycle.
	wire two_word_ret = bus.instr_return_req_a
		|| bus.data_return_req == mem_port_pkg::dret_two;
	wire ret_busy = two_word_ret && !stalled;
	wire can_take = !stalled && state_q != st_stall && !ret_busy;
	wire issue = cmd_valid_i && !half_odd && can_take;
	// The held request is answered in the first cycle after confirm falls.
	wire resp_ok = (state_q == st_wait || state_q == st_stall) && !stalled;
	wire [`MP_ADDR_W-1:0] issue_addr = is_fetch_seq_cmd ? fetch_next_q
		: (is_store_seq_cmd ? store_next_q : cmd_addr_i);
	wire [`MP_ADDR_W-1:0] fetch_after = issue_addr + `MP_ADDR_W'(8);
	wire [`MP_ADDR_W-1:0] store_after = issue_addr + `MP_ADDR_W'(4);
	wire got_done = resp_ok && bus.access_resp == mem_port_pkg::resp_done;
	wire got_abort = resp_ok && bus.access_resp == mem_port_pkg::resp_abort;
	wire got_notdone = resp_ok && bus.access_resp == mem_port_pkg::resp_notdone;
	assign cmd_ready_o = can_take && !half_odd;
	always_comb begin
		state_d = state_q;
		case (state_q)
			st_idle: begin
				if (issue) state_d = st_wait;
			end
			st_wait: begin
				if (stalled) state_d = st_stall;
				else if (!issue) state_d = st_idle;
			end
			st_stall: begin
				if (!stalled) state_d = st_idle;
			end
			default: state_d = st_idle;
		endcase
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= st_idle;
		end else begin
			state_q <= state_d;
		end
	end
	// Requests are held unchanged while the memory end is stalling.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus.access_req_type <= mem_port_pkg::acc_idle;
			bus.access_multi <= 1'b0;
			bus.instr_return_req_a <= 1'b0;
			bus.instr_return_req_b <= 1'b0;
			bus.data_return_req <= mem_port_pkg::dret_none;
		end else if (!stalled) begin
			bus.access_req_type <= issue ? cmd_type_i : mem_port_pkg::acc_idle;
			bus.access_multi <= issue && cmd_multi_i;
			bus.instr_return_req_a <= issue && cmd_ret_instr_i;
			bus.instr_return_req_b <= 1'b0;
			bus.data_return_req <= issue ? cmd_ret_data_i : mem_port_pkg::dret_none;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus.vaddr <= '0;
		end else if (issue) begin
			bus.vaddr <= issue_addr;
		end
	end
	// Sequential fetches and stores carry the address that follows the last one of their kind.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fetch_next_q <= '0;
			store_next_q <= '0;
		end else if (issue) begin
			if (is_fetch_cmd || is_fetch_seq_cmd) fetch_next_q <= fetch_after;
			if (is_store_cmd) store_next_q <= store_after;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			store_pend_q <= 1'b0;
			store_data_q <= '0;
		end else if (!stalled) begin
			store_pend_q <= issue && is_store_cmd;
			store_data_q <= cmd_wdata_i;
		end
	end
	// Store data follows its request by one cycle.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdata_q <= '0;
		end else if (store_pend_q) begin
			wdata_q <= store_data_q;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= bus.rdata_valid;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_is_data_o <= 1'b0;
		end else begin
			rd_is_data_o <= bus.rdata_is_data;
		end
	end
	// The last returned word stays visible until the next one arrives.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= '0;
		end else if (bus.rdata_valid) begin
			rd_data_o <= bus.rdata;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= got_done;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			abort_o <= 1'b0;
		end else begin
			abort_o <= got_abort;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			not_done_o <= 1'b0;
		end else begin
			not_done_o <= got_notdone;
		end
	end
	assign bus.wdata = wdata_q;
endmodule : core_side

// File: tb/port_checker.sv
// Concurrent checks on the request port between the core end and the memory end.
// Assumes one clock and the default miss length of three cycles.
`timescale 1ns/1ns
module port_checker (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire mem_port_pkg::access_req_t access_req_type,
	input wire logic [31:0] vaddr,
	input wire logic instr_return_req_a,
	input wire logic instr_return_req_b,
	input wire mem_port_pkg::data_ret_t data_return_req,
	input wire mem_port_pkg::access_resp_t access_resp,
	input wire logic rdata_valid,
	input wire logic confirm
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	stall_hold_a: assert property (confirm |=> $stable(access_req_type) && $stable(vaddr))
		else $error("request changed during a stall");
	odd_half_a: assert property (access_req_type == mem_port_pkg::acc_half_load |-> !vaddr[0])
		else $error("halfword request at odd address");
	instr_b_low_a: assert property (!instr_return_req_b)
		else $error("second instruction return line raised");
	two_words_a: assert property (instr_return_req_a && !confirm &&
		data_return_req == mem_port_pkg::dret_none |=> rdata_valid ##1 rdata_valid)
		else $error("instruction return did not bring two words");
	idle_notdone_a: assert property (access_req_type == mem_port_pkg::acc_idle |->
		access_resp == mem_port_pkg::resp_notdone)
		else $error("idle request not answered as not done");
	resp_legal_a: assert property (access_resp != 2'h3)
		else $error("illegal access response code");
	confirm_len_a: assert property ($rose(confirm) |-> confirm[*4] ##1 !confirm)
		else $error("stall length wrong");
	fell_done_a: assert property ($fell(confirm) && $past(reset_n_i) |->
		access_resp == mem_port_pkg::resp_done)
		else $error("stall ended without a completed response");
	cover property ($rose(confirm));
	cover property (instr_return_req_a && access_req_type == mem_port_pkg::acc_word_store);
	cover property (access_resp == mem_port_pkg::resp_notdone && |access_req_type);
endmodule : port_checker

// File: tb/testbench.sv
// Testbench joining the core end and the memory end through the port interface.
// Assumes default memory depth and miss length.
`timescale 1ns/1ns
module testbench;
	localparam logic [31:0] WA = 32'hA1B2C3D4;
	localparam logic [31:0] WB = 32'h5E6F7081;
	logic clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic cmd_valid = 1'h0;
	mem_port_pkg::access_req_t cmd_type = mem_port_pkg::acc_idle;
	logic cmd_multi = 1'h0;
	logic [31:0] cmd_addr = 32'h0;
	logic [31:0] cmd_wdata = 32'h0;
	logic cmd_ret_instr = 1'h0;
	mem_port_pkg::data_ret_t cmd_ret_data = mem_port_pkg::dret_none;
	logic big_endian = 1'h0;
	logic spec_decline = 1'h0;
	logic cmd_ready, rd_valid, rd_is_data, done, not_done, abort;
	logic [31:0] rd_data;
	int err_total = 0;
	int samples_checked = 0;
	mem_port_pkg::access_req_t lt [8] = '{mem_port_pkg::acc_word_load,
		mem_port_pkg::acc_word_load_seq, mem_port_pkg::acc_byte_load, mem_port_pkg::acc_byte_load,
		mem_port_pkg::acc_half_load, mem_port_pkg::acc_half_load,
		mem_port_pkg::acc_swap_word_rd, mem_port_pkg::acc_swap_byte_rd};
	logic [31:0] la [8] = '{32'h10, 32'h0, 32'h11, 32'h11, 32'h12, 32'h12, 32'h14, 32'h13};
	logic [31:0] lm [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FF00, 32'h00FF0000,
		32'hFFFF0000, 32'h0000FFFF, 32'hFFFFFFFF, 32'hFF000000};
	logic [7:0] lb = 8'h28;
	always #4 clk_i = ~clk_i;
	mem_port_if bus_if();
	core_side i_core_side (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid),
		.cmd_type_i(cmd_type), .cmd_multi_i(cmd_multi), .cmd_addr_i(cmd_addr),
		.cmd_wdata_i(cmd_wdata), .cmd_ret_instr_i(cmd_ret_instr), .cmd_ret_data_i(cmd_ret_data),
		.cmd_ready_o(cmd_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.rd_is_data_o(rd_is_data), .done_o(done), .abort_o(abort), .not_done_o(not_done),
		.bus(bus_if));
	mem_side i_mem_side (.clk_i(clk_i), .reset_n_i(reset_n_i), .big_endian_i(big_endian),
		.spec_decline_i(spec_decline), .bus(bus_if));
	port_checker i_port_checker (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.access_req_type(bus_if.access_req_type), .vaddr(bus_if.vaddr),
		.instr_return_req_a(bus_if.instr_return_req_a),
		.instr_return_req_b(bus_if.instr_return_req_b),
		.data_return_req(bus_if.data_return_req), .access_resp(bus_if.access_resp),
		.rdata_valid(bus_if.rdata_valid), .confirm(bus_if.confirm));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	function automatic logic flag(input int sel);
		return sel == 0 ? done : sel == 1 ? not_done : sel == 2 ? rd_valid : cmd_ready;
	endfunction : flag
	// Waits on a chosen handshake; a wait that runs out ends the run.
	task automatic wait_flag(input int sel);
		int n;
		n = 0;
		do @(negedge clk_i); while (flag(sel) !== 1'h1 && ++n < 60);
		check("handshake", {31'h0, flag(sel)}, 32'h1);
		if (n >= 60) begin
			give_verdict();
		end
	endtask : wait_flag
	task automatic issue(input mem_port_pkg::access_req_t t, input logic [31:0] a,
		input logic [31:0] d = 32'h0, input logic m = 1'h0, input logic ri = 1'h0,
		input mem_port_pkg::data_ret_t rd = mem_port_pkg::dret_none, input logic refuse = 1'h0);
		@(posedge clk_i);
		{cmd_type, cmd_addr, cmd_wdata, cmd_multi, cmd_ret_instr, cmd_ret_data} <=
			{t, a, d, m, ri, rd};
		cmd_valid <= 1'h1;
		if (refuse) begin
			repeat (2) @(negedge clk_i);
			check("ready on odd halfword", {31'h0, cmd_ready}, 32'h0);
		end else begin
			wait_flag(3);
		end
		@(posedge clk_i);
		cmd_valid <= 1'h0;
	endtask : issue
	task automatic get_word(input logic [31:0] exp, input logic [31:0] mask, input logic isd);
		wait_flag(2);
		check("read word", rd_data & mask, exp & mask);
		check("read kind", {31'h0, rd_is_data}, {31'h0, isd});
		check("abort flag", {31'h0, abort}, 32'h0);
	endtask : get_word
	initial begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'h1;
		issue(mem_port_pkg::acc_word_store, 32'h10, WA);
		wait_flag(0);
		issue(mem_port_pkg::acc_word_store_seq, 32'h0, WB);
		wait_flag(0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			big_endian <= lb[i];
			issue(lt[i], la[i], 32'h0, i == 0, 1'h0, mem_port_pkg::dret_one);
			get_word((i == 1 || la[i][2]) ? WB : WA, lm[i], 1'h1);
		end
		issue(mem_port_pkg::acc_word_load, 32'h110);
		wait_flag(0);
		@(posedge clk_i);
		spec_decline <= 1'h1;
		issue(mem_port_pkg::acc_ifetch_spec, 32'h10);
		wait_flag(1);
		issue(mem_port_pkg::acc_ifetch_spec_seq, 32'h18);
		wait_flag(1);
		issue(mem_port_pkg::acc_word_store, 32'h18, ~WA);
		wait_flag(0);
		issue(mem_port_pkg::acc_word_store_seq, 32'h0, ~WB);
		wait_flag(0);
		issue(mem_port_pkg::acc_ifetch, 32'h10, 32'h0, 1'h0, 1'h1);
		get_word(WA, 32'hFFFFFFFF, 1'h0);
		get_word(WB, 32'hFFFFFFFF, 1'h0);
		issue(mem_port_pkg::acc_ifetch_seq, 32'h0);
		wait_flag(0);
		issue(mem_port_pkg::acc_word_store, 32'h20, WA, 1'h0, 1'h1);
		get_word(~WA, 32'hFFFFFFFF, 1'h0);
		get_word(~WB, 32'hFFFFFFFF, 1'h0);
		issue(mem_port_pkg::acc_half_load, 32'h11, 32'h0, 1'h0, 1'h0, mem_port_pkg::dret_one, 1'h1);
		give_verdict();
	end
endmodule : testbench
